/* File: tks_defs.svh */
// Register offsets, field positions, reset values and counts of the touch key scanner.
`ifndef TKS_DEFS_SVH
`define TKS_DEFS_SVH
`define TKS_ADDR_W 8
`define TKS_OFF_CTRL 8'h00
`define TKS_OFF_STATUS 8'h04
`define TKS_OFF_FUNC 8'h08
`define TKS_OFF_MCTL0 8'h0C
`define TKS_OFF_MCTL1 8'h10
`define TKS_OFF_SENSE0 8'h14
`define TKS_OFF_SENSE1 8'h18
`define TKS_OFF_RELOAD0 8'h1C
`define TKS_OFF_RELOAD1 8'h20
`define TKS_CTRL_START 0
`define TKS_CTRL_SHARE 1
`define TKS_ST_RUN 0
`define TKS_ST_FUNC_OVF 1
`define TKS_ST_SENSE_OVF 2
`define TKS_MC_KEY_EN 0
`define TKS_MC_KEY_OSC 4
`define TKS_MC_REF_OSC 5
`define TKS_MC_SLOT_CLK 7
`define TKS_MC_KEY_SEL 8
`define TKS_MCTL_RST 10'h000
`define TKS_RELOAD_RST 8'h00
`define TKS_SYS_DIV 2'h3
`define TKS_RESP_OKAY 2'h0
`define TKS_RESP_SLVERR 2'h2
`endif

/* File: tks_pkg.sv */
// Types shared by the touch key scanner modules.
`default_nettype none
package tks_pkg;
	typedef enum logic [1:0] {
		TKS_IDLE = 2'b00,
		TKS_RUN  = 2'b01,
		TKS_DONE = 2'b10
	} tks_state_type;
	typedef struct packed {
		logic [1:0] keySel;
		logic       slotClockSelect;
		logic       spare;
		logic       refOscEnable;
		logic       keyOscEnable;
		logic [3:0] keyEnable;
	} tks_mod_ctrl_type;
endpackage
`default_nettype wire

/* File: tks_edge_sync.sv */
// Two-flop synchroniser with rising edge detect for oscillator outputs.
`default_nettype none
module tks_edge_sync #(
	parameter int W = 10
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         sys_rst,
	// Asynchronous oscillator levels and their edges
	input  wire logic [W-1:0] oscIn,
	output logic      [W-1:0] oscRise
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	logic [W-1:0] last_q;
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			meta_q <= '0;
			sync_q <= '0;
			last_q <= '0;
		end
		else
		begin
			meta_q <= oscIn;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end
	// One pulse per oscillator cycle, taken from the second stage and its copy in the third.
	assign oscRise = sync_q & ~last_q;
endmodule // tks_edge_sync
`default_nettype wire

/* File: tks_slot_unit.sv */
// One measurement module: sense counter, 8-bit slot counter and 5-bit unit period counter.
`default_nettype none
`include "tks_defs.svh"
module tks_slot_unit #(
	parameter int CW = 16,
	parameter int SW = 8,
	parameter int UW = 5
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          sys_rst,
	// Control
	input  wire logic          run,
	input  wire logic          startLow,
	input  wire logic          endClear,
	input  wire logic          tick,
	input  wire logic          senseEdge,
	input  wire logic [SW-1:0] slotReload,
	// Results
	output logic      [CW-1:0] senseCount,
	output logic               senseOvf,
	output logic               slotDone
);
	logic [SW-1:0] slot_q;
	logic [UW-1:0] unit_q;
	logic          slotWrap;
	assign slotWrap = run & tick & (slot_q == {SW{1'b1}});
	assign senseOvf = run & senseEdge & (senseCount == {CW{1'b1}});
	assign slotDone = slotWrap & (unit_q == {UW{1'b1}});
	always_ff @(posedge clk)
	begin
		if (sys_rst | startLow)
			senseCount <= '0;
		else if (run & senseEdge)
			senseCount <= senseCount + 1'b1;
	end
	// The programmable slot counter survives start low so a preset is kept.
	always_ff @(posedge clk)
	begin
		if (sys_rst | endClear)
			slot_q <= '0;
		else if (slotWrap)
			slot_q <= slotReload;
		else if (run & tick)
			slot_q <= slot_q + 1'b1;
	end
	always_ff @(posedge clk)
	begin
		if (sys_rst | startLow | endClear)
			unit_q <= '0;
		else if (slotWrap)
			unit_q <= unit_q + 1'b1;
	end
endmodule // tks_slot_unit
`default_nettype wire

/* File: tks_top.sv */
// Capacitive touch key scanner: two four-key modules behind an AXI4-Lite slave.
`default_nettype none
`include "tks_defs.svh"
module tks_top #(
	parameter int NMOD = 2,
	parameter int NKEY = 4
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	// AXI4-Lite write address and data
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// Oscillators on the touch pads
	input  wire logic [NMOD*NKEY-1:0] senseOsc,
	input  wire logic [NMOD-1:0]      refOsc,
	output logic [NMOD-1:0]           refOscRun,
	output logic [NMOD-1:0]           keyOscRun,
	output logic [NMOD*NKEY-1:0]      keyPinSelect,
	// Measurement end
	output logic                      touchIrq
);
	localparam int NOSC = NMOD * NKEY + NMOD;
	logic                              start_q;
	logic                              share_q;
	tks_pkg::tks_mod_ctrl_type         mctl_q [NMOD];
	logic [7:0]                        reload_q [NMOD];
	tks_pkg::tks_state_type            state_q;
	logic                              startPrev_q;
	logic [NMOD-1:0]                   fin_q;
	logic [1:0]                        div_q;
	logic [15:0]                       func_q;
	logic                              funcOvf_q;
	logic [NMOD-1:0]                   senseOvf_q;
	logic [NOSC-1:0]                   oscRise;
	logic [15:0]                       senseCount [NMOD];
	logic [NMOD-1:0]                   senseOvfNow;
	logic [NMOD-1:0]                   modDone;
	logic [NMOD-1:0]                   modRun;
	logic [NMOD-1:0]                   modTick;
	logic [NMOD-1:0]                   participates;
	logic                              sysTick;
	logic                              startRise;
	logic                              allDone;
	logic                              running;
	logic [7:0]                        awAddr_q;
	logic [31:0]                       wData_q;
	logic [3:0]                        wStrb_q;
	logic                              doWrite;
	logic                              wrStatus;
	logic [31:0]                       rdWord;
	logic                              rdHit;

	// Oscillator edges into the system domain.
	tks_edge_sync #(.W(NOSC)) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.oscIn   ({refOsc, senseOsc}),
		.oscRise (oscRise)
	);

	assign sysTick = (div_q == `TKS_SYS_DIV);
	assign startRise = start_q & ~startPrev_q;
	assign running = (state_q == tks_pkg::TKS_RUN);

	for (genvar m = 0; m < NMOD; m++)
	begin : g_mod
		logic senseSel;
		assign senseSel = oscRise[m*NKEY + 32'(mctl_q[m].keySel)] & mctl_q[m].keyEnable[mctl_q[m].keySel];
		assign modTick[m] = mctl_q[m].slotClockSelect ? sysTick : oscRise[NMOD*NKEY + m];
		assign modRun[m] = running & ~fin_q[m];
		assign participates[m] = |mctl_q[m].keyEnable;
		// Identical instances: module 0 holds keys 1 to 4, module 1 keys 5 to 8.
		tks_slot_unit u_unit (
			.clk        (clk),
			.sys_rst    (sys_rst),
			.run        (modRun[m]),
			.startLow   (~start_q),
			.endClear   (allDone),
			.tick       (modTick[m]),
			.senseEdge  (senseSel),
			.slotReload (reload_q[m]),
			.senseCount (senseCount[m]),
			.senseOvf   (senseOvfNow[m]),
			.slotDone   (modDone[m])
		);
	end

	// With sharing, or with no key enabled, module 0 alone ends the run; otherwise every taking-part module must finish.
	always_comb
	begin
		allDone = running;
		if (share_q)
			allDone = running & (modDone[0] | fin_q[0]);
		else
			for (int m = 0; m < NMOD; m++)
				if (participates[m] && !(modDone[m] || fin_q[m]))
					allDone = 1'b0;
		if (participates == '0 && !share_q)
			allDone = running & (modDone[0] | fin_q[0]);
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			div_q <= 2'h0;
		else
			div_q <= div_q + 2'h1;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			startPrev_q <= 1'b0;
		else
			startPrev_q <= start_q;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			state_q <= tks_pkg::TKS_IDLE;
		else if (!start_q)
			state_q <= tks_pkg::TKS_IDLE;
		else
		begin
			case (state_q)
				tks_pkg::TKS_IDLE: if (startRise) state_q <= tks_pkg::TKS_RUN;
				tks_pkg::TKS_RUN: if (allDone) state_q <= tks_pkg::TKS_DONE;
				tks_pkg::TKS_DONE: state_q <= tks_pkg::TKS_DONE;
				default: state_q <= tks_pkg::TKS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst | ~start_q | allDone)
			fin_q <= '0;
		else
			fin_q <= fin_q | (modDone & modRun);
	end

	// Calibration counter runs on the system clock divided by four and holds at the end.
	always_ff @(posedge clk)
	begin
		if (sys_rst | ~start_q)
			func_q <= 16'h0000;
		else if (running & sysTick)
			func_q <= func_q + 16'h0001;
	end

	// Oscillators start together on the start edge and stop with the run.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			refOscRun <= '0;
			keyOscRun <= '0;
			keyPinSelect <= '0;
			touchIrq <= 1'b0;
		end
		else
		begin
			for (int m = 0; m < NMOD; m++)
			begin
				refOscRun[m] <= (startRise | (running & ~allDone)) & mctl_q[m].refOscEnable;
				keyOscRun[m] <= (startRise | (running & ~allDone)) & mctl_q[m].keyOscEnable;
				keyPinSelect[m*NKEY +: NKEY] <= mctl_q[m].keyEnable;
			end
			touchIrq <= allDone;
		end
	end

	// AXI4-Lite write side: address and data are caught in either order.
	assign doWrite = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	assign wrStatus = doWrite && (awAddr_q == `TKS_OFF_STATUS) && wStrb_q[0];

	always_ff @(posedge clk)
	begin
		if (sys_rst | (s_axi_bvalid & s_axi_bready))
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
		else
		begin
			if (s_axi_awvalid & s_axi_awready)
				s_axi_awready <= 1'b0;
			if (s_axi_wvalid & s_axi_wready)
				s_axi_wready <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			awAddr_q <= 8'h00;
			wData_q <= 32'h00000000;
			wStrb_q <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid & s_axi_awready)
				awAddr_q <= s_axi_awaddr;
			if (s_axi_wvalid & s_axi_wready)
			begin
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TKS_RESP_OKAY;
		end
		else if (doWrite)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (awAddr_q > `TKS_OFF_RELOAD1 || awAddr_q[1:0] != 2'h0) ? `TKS_RESP_SLVERR : `TKS_RESP_OKAY;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			start_q <= 1'b0;
			share_q <= 1'b0;
			for (int m = 0; m < NMOD; m++)
			begin
				mctl_q[m] <= `TKS_MCTL_RST;
				reload_q[m] <= `TKS_RELOAD_RST;
			end
		end
		else if (doWrite)
		begin
			case (awAddr_q)
				`TKS_OFF_CTRL: if (wStrb_q[0])
				begin
					start_q <= wData_q[`TKS_CTRL_START];
					share_q <= wData_q[`TKS_CTRL_SHARE];
				end
				`TKS_OFF_MCTL0: if (wStrb_q[0] & wStrb_q[1]) mctl_q[0] <= wData_q[9:0];
				`TKS_OFF_MCTL1: if (wStrb_q[0] & wStrb_q[1]) mctl_q[1] <= wData_q[9:0];
				`TKS_OFF_RELOAD0: if (wStrb_q[0]) reload_q[0] <= wData_q[7:0];
				`TKS_OFF_RELOAD1: if (wStrb_q[0]) reload_q[1] <= wData_q[7:0];
				default: ;
			endcase
		end
	end

	// Sticky flags: an overflow in the same cycle as a clear keeps the flag set.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			funcOvf_q <= 1'b0;
			senseOvf_q <= '0;
		end
		else
		begin
			funcOvf_q <= (running & sysTick & (func_q == 16'hFFFF)) |
				(funcOvf_q & ~(wrStatus & wData_q[`TKS_ST_FUNC_OVF]));
			senseOvf_q <= senseOvfNow |
				(senseOvf_q & ~(wrStatus ? wData_q[`TKS_ST_SENSE_OVF +: NMOD] : '0));
		end
	end

	// AXI4-Lite read side: one read at a time, answered one cycle after the address.
	always_comb
	begin
		rdWord = 32'h00000000;
		rdHit = 1'b1;
		case (s_axi_araddr)
			`TKS_OFF_CTRL: rdWord[1:0] = {share_q, start_q};
			`TKS_OFF_STATUS: rdWord[3:0] = {senseOvf_q, funcOvf_q, running};
			`TKS_OFF_FUNC: rdWord[15:0] = func_q;
			`TKS_OFF_MCTL0: rdWord[9:0] = mctl_q[0];
			`TKS_OFF_MCTL1: rdWord[9:0] = mctl_q[1];
			`TKS_OFF_SENSE0: rdWord[15:0] = senseCount[0];
			`TKS_OFF_SENSE1: rdWord[15:0] = senseCount[1];
			`TKS_OFF_RELOAD0: rdWord[7:0] = reload_q[0];
			`TKS_OFF_RELOAD1: rdWord[7:0] = reload_q[1];
			default: rdHit = 1'b0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `TKS_RESP_OKAY;
		end
		else if (s_axi_arvalid & s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdWord;
			s_axi_rresp <= rdHit ? `TKS_RESP_OKAY : `TKS_RESP_SLVERR;
		end
		else if (s_axi_rready)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
		end
	end

	sequence startEdgeS;
		start_q && !startPrev_q && state_q == tks_pkg::TKS_IDLE;
	endsequence
	sequence runEndS;
		running && allDone && start_q;
	endsequence

	run_starts_a: assert property (
		@(posedge clk) disable iff (sys_rst) startEdgeS |=> running)
		else $error("run did not start after the start edge");
	osc_sync_a: assert property (
		@(posedge clk) disable iff (sys_rst) startEdgeS |=> (refOscRun == {mctl_q[1].refOscEnable, mctl_q[0].refOscEnable}))
		else $error("reference oscillators not enabled together");
	irq_pulse_a: assert property (
		@(posedge clk) disable iff (sys_rst) runEndS |=> touchIrq ##1 !touchIrq)
		else $error("interrupt not a single pulse at the end");
	osc_stop_a: assert property (
		@(posedge clk) disable iff (sys_rst) runEndS |=> (refOscRun == '0 && keyOscRun == '0 && !running))
		else $error("oscillators still running after the end");
	start_clear_a: assert property (
		@(posedge clk) disable iff (sys_rst) !start_q |=> (func_q == 16'h0000 && senseCount[0] == 16'h0000))
		else $error("counters not cleared while start is low");
	func_hold_a: assert property (
		@(posedge clk) disable iff (sys_rst) (state_q == tks_pkg::TKS_DONE && start_q) |=> $stable(func_q))
		else $error("function counter moved after the end");
	sense_sticky_a: assert property (
		@(posedge clk) disable iff (sys_rst) (senseOvf_q[0] && !(wrStatus && wData_q[`TKS_ST_SENSE_OVF]))
			|=> senseOvf_q[0])
		else $error("sense overflow flag dropped without a clear");
	func_sticky_a: assert property (
		@(posedge clk) disable iff (sys_rst) (running && sysTick && func_q == 16'hFFFF)
			|=> funcOvf_q ##1 (funcOvf_q || ($past(wrStatus) && $past(wData_q[`TKS_ST_FUNC_OVF]))))
		else $error("function overflow flag not held");
	slot_clock_a: assert property (
		@(posedge clk) disable iff (sys_rst) mctl_q[0].slotClockSelect |-> (modTick[0] == sysTick))
		else $error("slot clock select ignored");
	pin_route_a: assert property (
		@(posedge clk) disable iff (sys_rst) ##1 $stable(mctl_q[0]) |-> keyPinSelect[NKEY-1:0] == mctl_q[0].keyEnable)
		else $error("key pin routing does not follow its enable");
endmodule // tks_top
`default_nettype wire

/* File: tks_pad_model.sv */
// Behavioural touch pad oscillators that feed the scanner's sense and reference inputs.
`default_nettype none
module tks_pad_model #(
	parameter int KEY_HALF = 14,
	parameter int REF_HALF = 100
) (
	// Oscillator enables from the scanner
	input  wire logic [1:0] keyOscRun,
	input  wire logic [1:0] refOscRun,
	// Oscillator levels
	output logic      [7:0] senseOsc,
	output logic      [1:0] refOsc
);
	timeunit 1ns;
	timeprecision 100ps;
	logic keyLvl [8];
	logic refLvl [2];
	// Every pad runs at its own rate, so a count tells which key was measured.
	for (genvar k = 0; k < 8; k++)
	begin : g_key
		assign senseOsc[k] = keyLvl[k];
		initial
		begin
			keyLvl[k] = 1'b0;
			forever
			begin
				// Keys five to eight follow the second module's enable.
				wait (keyOscRun[k / 4] === 1'b1);
				#(KEY_HALF + 4 * k) keyLvl[k] = ~keyLvl[k];
			end
		end
	end
	for (genvar m = 0; m < 2; m++)
	begin : g_ref
		assign refOsc[m] = refLvl[m];
		initial
		begin
			refLvl[m] = 1'b0;
			forever
			begin
				// A stopped oscillator simply holds its last level.
				wait (refOscRun[m] === 1'b1);
				#(REF_HALF) refLvl[m] = ~refLvl[m];
			end
		end
	end
endmodule // tks_pad_model
`default_nettype wire

/* File: capacitive_touch_key_scanner_tb.sv */
// Self-checking bench for the touch key scanner, driven over AXI4-Lite.
`default_nettype none
`include "tks_defs.svh"
module capacitive_touch_key_scanner_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk;
	logic        sys_rst;
	logic [7:0]  s_axi_awaddr;
	logic        s_axi_awvalid;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_wvalid;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready;
	logic [7:0]  s_axi_araddr;
	logic        s_axi_arvalid;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready;
	logic [7:0]  senseOsc;
	logic [1:0]  refOsc;
	logic [1:0]  refOscRun;
	logic [1:0]  keyOscRun;
	logic [7:0]  keyPinSelect;
	logic        touchIrq;
	int          nErrors;
	int          checked;
	int          cycNow = 0;
	int          cyc;
	logic [31:0] rd;
	logic [1:0]  rsp;

	tks_top tks_top_i (
		.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.senseOsc, .refOsc, .refOscRun, .keyOscRun, .keyPinSelect, .touchIrq
	);
	tks_pad_model tks_pad_model_i (.keyOscRun, .refOscRun, .senseOsc, .refOsc);

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) cycNow <= cycNow + 1;

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, nErrors);
		if (nErrors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic timeout();
		nErrors++;
		$display("BAD wait expected answer seen timeout");
		complete_run();
	endtask
	function automatic logic [31:0] near(input logic [31:0] v, input int e, input int t);
		return ((int'(v) >= e - t) && (int'(v) <= e + t)) ? 32'h1 : 32'h0;
	endfunction
	// Valids and readies move only right after an edge and are held until taken.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (++n > 200)
				timeout();
		end
		while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (++n > 200)
				timeout();
		end
		while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axi_wr(a, d, rsp);
		check("write resp", {30'h0, rsp}, {30'h0, `TKS_RESP_OKAY});
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		axi_rd(a, rd, rsp);
		check(what, rd, exp);
		check("read resp", {30'h0, rsp}, {30'h0, `TKS_RESP_OKAY});
	endtask
	// Starts a run, checks the live state, and returns the cycles until the end pulse.
	task automatic run_meas(input logic [31:0] ctrl, input logic [1:0] oscExp, output int c);
		int t0;
		wr(`TKS_OFF_CTRL, ctrl);
		#1;
		t0 = cycNow;
		check("refOscRun", {30'h0, refOscRun}, {30'h0, oscExp});
		check("keyOscRun", {30'h0, keyOscRun}, {30'h0, oscExp});
		rd_chk("running", `TKS_OFF_STATUS, 32'h1);
		while (touchIrq !== 1'b1)
		begin
			if (cycNow - t0 > 40000)
				timeout();
			@(posedge clk);
			#1;
		end
		c = cycNow - t0;
		@(posedge clk);
		#1;
		check("irq pulse", {31'h0, touchIrq}, 32'h0);
		check("osc stop", {28'h0, refOscRun, keyOscRun}, 32'h0);
		rd_chk("ended", `TKS_OFF_STATUS, 32'h0);
	endtask

	initial
	begin
		sys_rst = 1'b1;
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		nErrors = 0;
		checked = 0;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		for (int a = 0; a <= 32; a += 4)
			rd_chk("reset value", 8'(a), 32'h0);
		axi_rd(8'h24, rd, rsp);
		check("unmapped rresp", {30'h0, rsp}, {30'h0, `TKS_RESP_SLVERR});
		check("unmapped rdata", rd, 32'h0);
		axi_wr(8'h40, 32'hFFFF_FFFF, rsp);
		check("unmapped bresp", {30'h0, rsp}, {30'h0, `TKS_RESP_SLVERR});
		$display("test reset done");
		// Module 0: keys one and two, key two counted, slot clock from system/4.
		wr(`TKS_OFF_MCTL0, 32'h0000_01B3);
		#1;
		check("pin select", {24'h0, keyPinSelect}, 32'h0000_0003);
		rd_chk("mctl0", `TKS_OFF_MCTL0, 32'h0000_01B3);
		wr(`TKS_OFF_RELOAD0, 32'h0000_00F0);
		wr(`TKS_OFF_RELOAD1, 32'h0000_00F0);
		// One first slot of 256 ticks, then 31 reloaded slots of 16 ticks, 4 clocks a tick.
		run_meas(32'h1, 2'b01, cyc);
		check("run length", near(cyc, 3008, 16), 32'h1);
		axi_rd(`TKS_OFF_FUNC, rd, rsp);
		check("func count", near(rd, cyc / 4, 4), 32'h1);
		axi_rd(`TKS_OFF_SENSE0, rd, rsp);
		check("sense0 count", near(rd, cyc * 8 / 36, 4), 32'h1);
		wr(`TKS_OFF_CTRL, 32'h1);
		repeat (8) @(posedge clk);
		rd_chk("no restart", `TKS_OFF_STATUS, 32'h0);
		axi_rd(`TKS_OFF_FUNC, rd, rsp);
		check("func held", near(rd, cyc / 4, 4), 32'h1);
		wr(`TKS_OFF_CTRL, 32'h0);
		rd_chk("func cleared", `TKS_OFF_FUNC, 32'h0);
		rd_chk("sense cleared", `TKS_OFF_SENSE0, 32'h0);
		$display("test single module done");
		// Module 1 on its slow reference oscillator, key seven counted.
		wr(`TKS_OFF_MCTL1, 32'h0000_0234);
		#1;
		check("pin select", {24'h0, keyPinSelect}, 32'h0000_0043);
		run_meas(32'h3, 2'b11, cyc);
		check("shared length", near(cyc, 3008, 16), 32'h1);
		axi_rd(`TKS_OFF_SENSE1, rd, rsp);
		check("sense1 count", near(rd, cyc * 8 / 76, 4), 32'h1);
		wr(`TKS_OFF_CTRL, 32'h0);
		$display("test shared slot done");
		// Without sharing, the slow module sets the end: 752 ticks of 200 ns.
		run_meas(32'h1, 2'b11, cyc);
		check("both length", near(cyc, 18800, 60), 32'h1);
		axi_rd(`TKS_OFF_SENSE1, rd, rsp);
		check("sense1 count", near(rd, cyc * 8 / 76, 4), 32'h1);
		wr(`TKS_OFF_CTRL, 32'h0);
		rd_chk("sense1 cleared", `TKS_OFF_SENSE1, 32'h0);
		$display("test two modules done");
		complete_run();
	end
endmodule // capacitive_touch_key_scanner_tb
`default_nettype wire
